//--- src/sdpe_pkg.sv
// What this block does
// - each element has primary and secondary banks of sixteen 40-bit regs.
// - the primary bank is active after reset, the secondary when selected.
// - ALU, multiplier and shifter finish each operation in one cycle.
// - any unit's result is an operand for any unit on the very next cycle.
// - the primary element executes every computational instruction.
// - the secondary element follows in lock-step only in multiple-data mode.
// - operands come as 32-bit fixed, 32-bit float or 40-bit float.
// - 32-bit float uses the IEEE single layout and single precision.
// - 40-bit float is the 32-bit layout with eight extra low mantissa bits.
// - fixed point covers integer and fraction, each signed or unsigned.
// - the ALU does arithmetic and logic on fixed and float operands.
// - multiply fixed or float, fixed MAC and MSUB into an 80-bit acc.
// - the shifter shifts, edits bits and fields and derives exponents.
// - ALU and multiplier work at once and independently when paired.
// - each cycle allows two memory accesses, six operands, three results.
// - an arithmetic exception raises an interrupt or sets a sticky flag.
package sdpe_pkg;
   localparam int SDPE_NREG  = 16;
   localparam int SDPE_AW    = 4;
   localparam int SDPE_DW    = 40;
   localparam int SDPE_ACCW  = 80;
   localparam int SDPE_FIXW  = 32;
   localparam int SDPE_EXTW  = 8;     // extra low mantissa bits of 40-bit float
   localparam int SDPE_NFLAG = 4;
   // status flag positions
   localparam int ST_AOV = 0;
   localparam int ST_MOV = 1;
   localparam int ST_FOV = 2;
   localparam int ST_FUN = 3;
   // float layout
   localparam logic [7:0]       FLT_EMAX  = 8'hFF;
   localparam logic signed [9:0] FLT_BIAS = 10'sh07F;
   localparam logic signed [9:0] FLT_HID  = 10'sh01F; // hidden bit index
   // field layout of the shifter control operand
   localparam int SH_POS_LSB = 0;
   localparam int SH_LEN_LSB = 6;
   localparam int SH_FLD_W   = 6;
   localparam logic SDPE_BANK_RST = 1'b0;
   typedef enum logic [1:0] {
      FMT_FIX = 2'h0, FMT_F32 = 2'h1, FMT_F40 = 2'h2
   } sdpe_fmt_e;
   typedef enum logic [2:0] {
      ALU_ADD = 3'h0, ALU_SUB = 3'h1, ALU_AND = 3'h2, ALU_OR = 3'h3,
      ALU_XOR = 3'h4, ALU_PASS = 3'h5, ALU_ABS = 3'h6, ALU_NOT = 3'h7
   } sdpe_alu_e;
   typedef enum logic [1:0] {
      MUL_MUL = 2'h0, MUL_MAC = 2'h1, MUL_MSUB = 2'h2, MUL_CLR = 2'h3
   } sdpe_mul_e;
   typedef enum logic [2:0] {
      SHF_LSH = 3'h0, SHF_ASH = 3'h1, SHF_BSET = 3'h2, SHF_BCLR = 3'h3,
      SHF_BTGL = 3'h4, SHF_FDEP = 3'h5, SHF_FEXT = 3'h6, SHF_EXP = 3'h7
   } sdpe_shf_e;
endpackage

//--- src/sdpe_top.sv
`timescale 1ns/100ps
module sdpe_elem
   import sdpe_pkg::*;
(
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   nrst,
   // mode
   input  wire logic                   exec,
   input  wire logic                   alt_bank,
   input  wire logic                   exc_irq_mode,
   input  wire sdpe_fmt_e              fmt,
   input  wire logic                   fix_uns,
   input  wire logic                   fix_frac,
   // alu
   input  wire logic                   alu_en,
   input  wire sdpe_alu_e              alu_op,
   input  wire logic [SDPE_AW-1:0]     alu_a,
   input  wire logic [SDPE_AW-1:0]     alu_b,
   input  wire logic [SDPE_AW-1:0]     alu_dst,
   // multiplier
   input  wire logic                   mul_en,
   input  wire sdpe_mul_e              mul_op,
   input  wire logic [SDPE_AW-1:0]     mul_a,
   input  wire logic [SDPE_AW-1:0]     mul_b,
   input  wire logic [SDPE_AW-1:0]     mul_dst,
   // shifter
   input  wire logic                   shf_en,
   input  wire sdpe_shf_e              shf_op,
   input  wire logic [SDPE_AW-1:0]     shf_a,
   input  wire logic [SDPE_AW-1:0]     shf_b,
   input  wire logic [SDPE_AW-1:0]     shf_dst,
   // memory ports
   input  wire logic [1:0]             mem_en,
   input  wire logic [1:0]             mem_we,
   input  wire logic [2*SDPE_AW-1:0]   mem_addr,
   input  wire logic [2*SDPE_DW-1:0]   mem_wdata,
   output logic      [2*SDPE_DW-1:0]   mem_rdata,
   // exceptions
   input  wire logic [SDPE_NFLAG-1:0]  flag_clr,
   output logic      [SDPE_NFLAG-1:0]  flags,
   output logic                        exc_irq
);
   logic [SDPE_DW-1:0]   rf_q [2][SDPE_NREG];
   logic [SDPE_DW-1:0]   rf_d [2][SDPE_NREG];
   logic                 bank_q;
   logic [SDPE_ACCW-1:0] acc_q, acc_d;
   logic [SDPE_NFLAG-1:0] flags_q, flags_d, ev;
   logic                 irq_q, irq_d;
   logic [2*SDPE_DW-1:0] rd_q, rd_d;
   logic [SDPE_DW-1:0]   ra, rb, ma, mb, sa, sb, alu_r, mul_r, shf_r;
   logic [41:0]          fr_alu, fr_mul;
   logic [31:0]          a32, b32, m32, n32, s32, t32, x32, y32;
   logic signed [63:0]   prod;
   logic [SDPE_ACCW-1:0] chk;
   logic [63:0]          fmask;
   logic [5:0]           fpos, flen;
   logic                 aov, mov;

   // float add on the 40-bit layout: {ovf, unf, result}
   function automatic logic [41:0] f_add(input logic [39:0] x,
                                         input logic [39:0] y);
      logic [39:0]        t;
      logic [31:0]        mx, my;
      logic [32:0]        s, n;
      logic [7:0]         ed;
      logic               sr;
      logic signed [9:0]  er;
      int                 p;
      t = x;
      if (x[38:31] < y[38:31]) begin
         x = y;
         y = t;
      end
      mx = (x[38:31] == 8'h00) ? 32'h0 : {1'b1, x[30:0]};
      my = (y[38:31] == 8'h00) ? 32'h0 : {1'b1, y[30:0]};
      ed = x[38:31] - y[38:31];
      my = (ed > 8'd31) ? 32'h0 : my >> ed;   // alignment, truncating
      sr = x[39];
      if (x[39] == y[39]) begin
         s = {1'b0, mx} + {1'b0, my};
      end else if (mx >= my) begin
         s = {1'b0, mx} - {1'b0, my};
      end else begin
         s = {1'b0, my} - {1'b0, mx};
         sr = y[39];
      end
      p = 0;
      for (int i = 0; i < 33; i++) begin
         if (s[i]) p = i;
      end
      n = (p == 32) ? (s >> 1) : (s << (31 - p));
      er = $signed({2'b00, x[38:31]}) + 10'(p) - FLT_HID;
      if (s == 33'h0) f_add = 42'h0;
      else if (er >= $signed({2'b00, FLT_EMAX}))
         f_add = {2'b10, sr, FLT_EMAX, 31'h0};
      else if (er <= 10'sh000) f_add = {2'b01, 40'h0};
      else f_add = {2'b00, sr, er[7:0], n[30:0]};
   endfunction

   // float multiply on the 40-bit layout: {ovf, unf, result}
   function automatic logic [41:0] f_mul(input logic [39:0] x,
                                         input logic [39:0] y);
      logic [63:0]        m;
      logic signed [9:0]  er;
      logic               sr;
      sr = x[39] ^ y[39];
      m = {1'b1, x[30:0]} * {1'b1, y[30:0]};
      er = $signed({2'b00, x[38:31]}) + $signed({2'b00, y[38:31]})
           - FLT_BIAS + $signed({9'h000, m[63]});
      if (x[38:31] == 8'h00 || y[38:31] == 8'h00) f_mul = 42'h0;
      else if (er >= $signed({2'b00, FLT_EMAX}))
         f_mul = {2'b10, sr, FLT_EMAX, 31'h0};
      else if (er <= 10'sh000) f_mul = {2'b01, 40'h0};
      else f_mul = {2'b00, sr, er[7:0], m[63] ? m[62:32] : m[61:31]};
   endfunction

   // operand reads straight from the active bank, so a result written
   // at one edge is an operand in the next cycle
   always_comb begin
      ra = rf_q[bank_q][alu_a];
      rb = rf_q[bank_q][alu_b];
      ma = rf_q[bank_q][mul_a];
      mb = rf_q[bank_q][mul_b];
      sa = rf_q[bank_q][shf_a];
      sb = rf_q[bank_q][shf_b];
      if (fmt == FMT_F32) begin
         ra[SDPE_EXTW-1:0] = 8'h00;
         rb[SDPE_EXTW-1:0] = 8'h00;
         ma[SDPE_EXTW-1:0] = 8'h00;
         mb[SDPE_EXTW-1:0] = 8'h00;
      end
   end

   // alu, one combinational stage
   always_comb begin
      a32 = ra[SDPE_DW-1:SDPE_EXTW];                    // fixed sits high
      b32 = rb[SDPE_DW-1:SDPE_EXTW];
      fr_alu = 42'h0;
      aov = 1'b0;
      t32 = 32'h0;
      case (alu_op)
         ALU_ADD: {aov, t32} = {1'b0, a32} + {1'b0, b32};
         ALU_SUB: {aov, t32} = {1'b0, a32} - {1'b0, b32};
         ALU_AND: t32 = a32 & b32;
         ALU_OR:  t32 = a32 | b32;
         ALU_XOR: t32 = a32 ^ b32;
         ALU_PASS: t32 = a32;
         ALU_ABS: t32 = a32[31] ? 32'h0 - a32 : a32;
         default: t32 = ~a32;
      endcase
      if (!fix_uns && (alu_op == ALU_ADD || alu_op == ALU_SUB))
         aov = (a32[31] == (b32[31] ^ (alu_op == ALU_SUB)))
               && (t32[31] != a32[31]);
      alu_r = {t32, 8'h00};
      if (fmt != FMT_FIX) begin
         aov = 1'b0;
         case (alu_op)
            ALU_ADD: fr_alu = f_add(ra, rb);
            ALU_SUB: fr_alu = f_add(ra, {~rb[39], rb[38:0]});
            ALU_ABS: fr_alu = {2'b00, 1'b0, ra[38:0]};
            ALU_PASS: fr_alu = {2'b00, ra};
            default: fr_alu = {2'b00, alu_r};
         endcase
         alu_r = fr_alu[39:0];
         if (fmt == FMT_F32) alu_r[SDPE_EXTW-1:0] = 8'h00;
      end
   end

   // multiplier and 80-bit accumulator, independent of the alu
   always_comb begin
      m32 = ma[SDPE_DW-1:SDPE_EXTW];
      n32 = mb[SDPE_DW-1:SDPE_EXTW];
      prod = fix_uns ? $signed(64'(m32) * 64'(n32))
                     : $signed(m32) * $signed(n32);
      if (fix_frac) prod = prod <<< 1;
      acc_d = acc_q;
      fr_mul = f_mul(ma, mb);
      if (exec && mul_en && fmt == FMT_FIX) begin
         case (mul_op)
            MUL_MUL:  acc_d = {{16{prod[63] & ~fix_uns}}, prod};
            MUL_MAC:  acc_d = acc_q + {{16{prod[63] & ~fix_uns}}, prod};
            MUL_MSUB: acc_d = acc_q - {{16{prod[63] & ~fix_uns}}, prod};
            default:  acc_d = '0;
         endcase
      end
      chk = fix_frac ? 80'($signed(acc_d) >>> 32) : acc_d;
      mov = fix_uns ? |chk[79:32]
                    : !(&chk[79:31] || !(|chk[79:31]));
      mul_r = {chk[31:0], 8'h00};
      if (fmt != FMT_FIX) begin                         // float multiply
         mov = 1'b0;
         mul_r = fr_mul[39:0];
         if (fmt == FMT_F32) mul_r[SDPE_EXTW-1:0] = 8'h00;
      end
   end

   // shifter on 32-bit operands; own operand copies so that the alu
   // process stays the only driver of its own
   always_comb begin
      x32 = sa[SDPE_DW-1:SDPE_EXTW];
      y32 = sb[SDPE_DW-1:SDPE_EXTW];
      fpos = y32[SH_POS_LSB +: SH_FLD_W];
      flen = y32[SH_LEN_LSB +: SH_FLD_W];
      fmask = ((64'h1 << flen) - 64'h1) << fpos;
      s32 = 32'h0;
      case (shf_op)
         SHF_LSH: s32 = y32[7] ? x32 >> (8'h00 - y32[7:0])
                               : x32 << y32[7:0];
         SHF_ASH: s32 = y32[7] ? 32'($signed(x32) >>> (8'h00 - y32[7:0]))
                               : x32 << y32[7:0];
         SHF_BSET: s32 = x32 | (32'h1 << y32[4:0]);
         SHF_BCLR: s32 = x32 & ~(32'h1 << y32[4:0]);
         SHF_BTGL: s32 = x32 ^ (32'h1 << y32[4:0]);
         SHF_FDEP: s32 = 32'((64'(x32) << fpos) & fmask);
         SHF_FEXT: s32 = 32'((64'(x32) & fmask) >> fpos);
         default: begin                 // exponent: minus redundant signs
            for (int i = 30; i >= 0; i--) begin
               if (x32[i] != x32[31] && s32 == 32'h0)
                  s32 = 32'(30 - i);
            end
            if (s32 == 32'h0 && x32[0] == x32[31] && x32[31:1] ==
                {31{x32[31]}}) s32 = 32'd31;
            s32 = 32'h0 - s32;
         end
      endcase
      shf_r = {s32, 8'h00};
   end

   // register file next state: memory writes, then unit results
   always_comb begin
      rf_d = rf_q;
      for (int p = 0; p < 2; p++) begin
         if (mem_en[p] && mem_we[p])
            rf_d[bank_q][mem_addr[p*SDPE_AW +: SDPE_AW]] =
               mem_wdata[p*SDPE_DW +: SDPE_DW];
      end
      if (exec) begin
         if (alu_en) rf_d[bank_q][alu_dst] = alu_r;
         if (mul_en && mul_op != MUL_CLR) rf_d[bank_q][mul_dst] = mul_r;
         if (shf_en) rf_d[bank_q][shf_dst] = shf_r;
      end
      rd_d = rd_q;
      for (int p = 0; p < 2; p++) begin
         if (mem_en[p] && !mem_we[p])
            rd_d[p*SDPE_DW +: SDPE_DW] =
               rf_q[bank_q][mem_addr[p*SDPE_AW +: SDPE_AW]];
      end
   end

   // exception events: either an interrupt pulse or sticky flags
   always_comb begin
      ev = '0;
      if (exec) begin
         ev[ST_AOV] = alu_en && aov;
         ev[ST_MOV] = mul_en && mov;
         ev[ST_FOV] = (alu_en && fmt != FMT_FIX && fr_alu[41]) ||
                      (mul_en && fmt != FMT_FIX && fr_mul[41]);
         ev[ST_FUN] = (alu_en && fmt != FMT_FIX && fr_alu[40]) ||
                      (mul_en && fmt != FMT_FIX && fr_mul[40]);
      end
      // set beats clear so an event in the clearing cycle survives
      flags_d = (flags_q & ~flag_clr) | (exc_irq_mode ? '0 : ev);
      irq_d   = exc_irq_mode && (|ev);
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rf_q    <= '{default: '{default: '0}};
         bank_q  <= SDPE_BANK_RST;
         acc_q   <= '0;
         flags_q <= '0;
         irq_q   <= 1'b0;
         rd_q    <= '0;
      end else begin
         rf_q    <= rf_d;
         bank_q  <= alt_bank;
         acc_q   <= acc_d;
         flags_q <= flags_d;
         irq_q   <= irq_d;
         rd_q    <= rd_d;
      end
   end

   assign mem_rdata = rd_q;
   assign flags     = flags_q;
   assign exc_irq   = irq_q;
endmodule

module sdpe_top
   import sdpe_pkg::*;
(
   // clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   nrst,
   // mode
   input  wire logic                   simd_en,
   input  wire logic                   alt_bank,
   input  wire logic                   exc_irq_mode,
   input  wire sdpe_fmt_e              fmt,
   input  wire logic                   fix_uns,
   input  wire logic                   fix_frac,
   // shared instruction fields
   input  wire logic                   alu_en,
   input  wire sdpe_alu_e              alu_op,
   input  wire logic [3*SDPE_AW-1:0]   alu_regs,  // dst, b, a
   input  wire logic                   mul_en,
   input  wire sdpe_mul_e              mul_op,
   input  wire logic [3*SDPE_AW-1:0]   mul_regs,
   input  wire logic                   shf_en,
   input  wire sdpe_shf_e              shf_op,
   input  wire logic [3*SDPE_AW-1:0]   shf_regs,
   // memory ports, primary then secondary element
   input  wire logic [3:0]             mem_en,
   input  wire logic [3:0]             mem_we,
   input  wire logic [4*SDPE_AW-1:0]   mem_addr,
   input  wire logic [4*SDPE_DW-1:0]   mem_wdata,
   output logic      [4*SDPE_DW-1:0]   mem_rdata,
   // exceptions, primary then secondary element
   input  wire logic [2*SDPE_NFLAG-1:0] flag_clr,
   output logic      [2*SDPE_NFLAG-1:0] flags,
   output logic                         exc_irq
);
   logic [1:0] irq;

   // one instance per element; exec and the memory and flag slices differ
   for (genvar e = 0; e < 2; e++) begin : g_pe
      sdpe_elem u_pe (
         .clk_sys      (clk_sys),
         .nrst         (nrst),
         .exec         (e == 0 ? 1'b1 : simd_en),
         .alt_bank     (alt_bank),
         .exc_irq_mode (exc_irq_mode),
         .fmt          (fmt),
         .fix_uns      (fix_uns),
         .fix_frac     (fix_frac),
         .alu_en       (alu_en),
         .alu_op       (alu_op),
         .alu_a        (alu_regs[0 +: SDPE_AW]),
         .alu_b        (alu_regs[SDPE_AW +: SDPE_AW]),
         .alu_dst      (alu_regs[2*SDPE_AW +: SDPE_AW]),
         .mul_en       (mul_en),
         .mul_op       (mul_op),
         .mul_a        (mul_regs[0 +: SDPE_AW]),
         .mul_b        (mul_regs[SDPE_AW +: SDPE_AW]),
         .mul_dst      (mul_regs[2*SDPE_AW +: SDPE_AW]),
         .shf_en       (shf_en),
         .shf_op       (shf_op),
         .shf_a        (shf_regs[0 +: SDPE_AW]),
         .shf_b        (shf_regs[SDPE_AW +: SDPE_AW]),
         .shf_dst      (shf_regs[2*SDPE_AW +: SDPE_AW]),
         .mem_en       (mem_en[2*e +: 2]),
         .mem_we       (mem_we[2*e +: 2]),
         .mem_addr     (mem_addr[2*e*SDPE_AW +: 2*SDPE_AW]),
         .mem_wdata    (mem_wdata[2*e*SDPE_DW +: 2*SDPE_DW]),
         .mem_rdata    (mem_rdata[2*e*SDPE_DW +: 2*SDPE_DW]),
         .flag_clr     (flag_clr[e*SDPE_NFLAG +: SDPE_NFLAG]),
         .flags        (flags[e*SDPE_NFLAG +: SDPE_NFLAG]),
         .exc_irq      (irq[e])
      );
   end

   assign exc_irq = |irq;
endmodule

//--- verification/sdpe_checker_assertions.sv
`timescale 1ns/100ps
// port-level watch on flags, interrupt pulse and read data
module sdpe_checker
   import sdpe_pkg::*;
(
   // clock and reset
   input wire logic                    clk_sys,
   input wire logic                    nrst,
   // mode and strobes
   input wire logic                    simd_en,
   input wire logic                    exc_irq_mode,
   input wire logic                    alu_en,
   input wire logic                    mul_en,
   input wire logic                    shf_en,
   input wire logic [3:0]              mem_en,
   input wire logic [3:0]              mem_we,
   input wire logic [2*SDPE_NFLAG-1:0] flag_clr,
   // results
   input wire logic [4*SDPE_DW-1:0]    mem_rdata,
   input wire logic [2*SDPE_NFLAG-1:0] flags,
   input wire logic                    exc_irq
);
   logic units;
   // only a unit strobe can raise an exception
   assign units = alu_en | mul_en | shf_en;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   // exception handling: flag or pulse, each with a cause
   rst_clear_a: assert property ($rose(nrst) |->
      flags == 8'h00 && !exc_irq && mem_rdata == '0)
      else $error("state not clear after reset");
   irq_cause_a: assert property (exc_irq |->
      $past(exc_irq_mode && units)) else $error("pulse without cause");
   flag_cause_a: assert property ((flags & ~$past(flags)) != 8'h00 |->
      $past(!exc_irq_mode && units)) else $error("flag set without cause");
   irq_noflag_a: assert property (exc_irq_mode |=>
      (flags & ~$past(flags)) == 8'h00) else $error("flag set in irq mode");
   flag_hold_a: assert property (!units && flag_clr == 8'h00 |=>
      $stable(flags)) else $error("flags moved while idle");
   flag_clr_a: assert property (flag_clr != 8'h00 && !units |=>
      (flags & $past(flag_clr)) == 8'h00) else $error("flag not cleared");
   // secondary flags frozen outside multiple-data mode
   sec_keep_a: assert property (!simd_en && flag_clr[7:4] == 4'h0 |=>
      $stable(flags[7:4])) else $error("secondary flags moved");
   // read data holds until a read on some port
   rd_hold_a: assert property ((mem_en & ~mem_we) == 4'h0 |=>
      $stable(mem_rdata)) else $error("read data moved without a read");
   // main scenarios reached
   cover property (exc_irq);
   cover property (flags[ST_AOV]);
   cover property (simd_en && alu_en);
endmodule

bind sdpe_top sdpe_checker chk_u (.clk_sys, .nrst, .simd_en, .exc_irq_mode,
   .alu_en, .mul_en, .shf_en, .mem_en, .mem_we, .flag_clr, .mem_rdata,
   .flags, .exc_irq);

//--- verification/sdpe_mem_model.sv
`timescale 1ns/100ps
// memory-side partner: passes bench requests onto the element ports
module sdpe_mem_model
   import sdpe_pkg::*;
(
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 nrst,
   // bench requests
   input  wire logic [3:0]           c_en,
   input  wire logic [3:0]           c_we,
   input  wire logic [4*SDPE_AW-1:0] c_addr,
   input  wire logic [4*SDPE_DW-1:0] c_wdata,
   // element memory ports
   output logic      [3:0]           mem_en,
   output logic      [3:0]           mem_we,
   output logic      [4*SDPE_AW-1:0] mem_addr,
   output logic      [4*SDPE_DW-1:0] mem_wdata
);
   logic [4*SDPE_DW-1:0] last_q;
   // last driven word, so a released port never repeats it
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         last_q <= '0;
      end else begin
         last_q <= mem_wdata;
      end
   end
   // two ports per element each cycle; idle data toggles
   always_comb begin
      mem_en = c_en;
      mem_we = c_we & c_en;
      mem_addr = c_addr;
      for (int i = 0; i < 4; i++) begin
         mem_wdata[i*40 +: 40] = c_en[i] ? c_wdata[i*40 +: 40]
                                         : ~last_q[i*40 +: 40];
      end
   end
endmodule

//--- verification/test_dual_simd_processing_elements.sv
`timescale 1ns/100ps
module test_dual_simd_processing_elements
   import sdpe_pkg::*;
;
   // design inputs, partner requests and observed outputs
   logic                 clk_sys, nrst, simd_en, alt_bank, exc_irq_mode;
   logic                 fix_uns, fix_frac, alu_en, mul_en, shf_en;
   sdpe_fmt_e            fmt;
   sdpe_alu_e            alu_op;
   sdpe_mul_e            mul_op;
   sdpe_shf_e            shf_op;
   logic [3*SDPE_AW-1:0] alu_regs, mul_regs, shf_regs;
   logic [3:0]           c_en, c_we, mem_en, mem_we;
   logic [4*SDPE_AW-1:0] c_addr, mem_addr;
   logic [4*SDPE_DW-1:0] c_wdata, mem_wdata, mem_rdata;
   logic [7:0]           flag_clr, flags;
   logic                 exc_irq;
   int                   n_mismatch, n_checks;
   // 20 MHz clock
   initial clk_sys = 1'b0;
   always #25 clk_sys = ~clk_sys;
   // device and memory-side partner
   sdpe_top dut_u (.clk_sys, .nrst, .simd_en, .alt_bank, .exc_irq_mode,
      .fmt, .fix_uns, .fix_frac, .alu_en, .alu_op, .alu_regs, .mul_en,
      .mul_op, .mul_regs, .shf_en, .shf_op, .shf_regs, .mem_en, .mem_we,
      .mem_addr, .mem_wdata, .mem_rdata, .flag_clr, .flags, .exc_irq);
   sdpe_mem_model mem_u (.clk_sys, .nrst, .c_en, .c_we, .c_addr, .c_wdata,
      .mem_en, .mem_we, .mem_addr, .mem_wdata);
   // compare a register word
   task chk_reg(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t reg %h exp %h", $time, got, exp);
      end
   endtask
   // compare {exc_irq, flags}
   task chk_st(input logic [8:0] got, input logic [8:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t status %h exp %h", $time, got, exp);
      end
   endtask
   task close_out();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // one write on port p; released a cycle later to avoid double drive
   task mem_wr(input int p, input logic [3:0] r, input logic [39:0] v);
      c_en <= 4'h1 << p;
      c_we <= 4'h1 << p;
      c_addr[4*p +: 4] <= r;
      c_wdata[40*p +: 40] <= v;
      @(posedge clk_sys);
      c_en <= 4'h0;
      c_we <= 4'h0;
      @(posedge clk_sys);
   endtask
   // read on port p; data holds, so one extra edge is safe
   task mem_rd(input int p, input logic [3:0] r, input logic [39:0] exp);
      c_en <= 4'h1 << p;
      c_addr[4*p +: 4] <= r;
      @(posedge clk_sys);
      c_en <= 4'h0;
      @(posedge clk_sys);
      chk_reg(mem_rdata[40*p +: 40], exp);
   endtask
   // unit strobes for one cycle
   task go(input logic a, input logic m, input logic s);
      alu_en <= a;
      mul_en <= m;
      shf_en <= s;
      @(posedge clk_sys);
   endtask
   function logic [39:0] fx(input logic [31:0] v);
      return {v, 8'h00};
   endfunction
   // reset state, then primary and secondary banks stay apart
   task t_bank();
      chk_st({exc_irq, flags}, 9'h000);
      mem_wr(0, 4'hF, 40'hA5_1234_5678);
      alt_bank <= 1'b1;
      go(1'b0, 1'b0, 1'b0);
      mem_rd(0, 4'hF, 40'h00_0000_0000);
      mem_wr(0, 4'hF, 40'h5A_8765_4321);
      mem_rd(0, 4'hF, 40'h5A_8765_4321);
      alt_bank <= 1'b0;
      go(1'b0, 1'b0, 1'b0);
      mem_rd(0, 4'hF, 40'hA5_1234_5678);
   endtask
   // alu and multiplier side by side, results used the next cycle
   task t_fwd();
      mem_wr(0, 4'h1, fx(32'h5));
      mem_wr(0, 4'h2, fx(32'h7));
      mem_wr(0, 4'h7, fx(32'h4));
      alu_op <= ALU_ADD;
      alu_regs <= {4'h3, 4'h2, 4'h1};
      mul_op <= MUL_MUL;
      mul_regs <= {4'h4, 4'h2, 4'h1};
      go(1'b1, 1'b1, 1'b0);
      mul_regs <= {4'h5, 4'h2, 4'h3};
      shf_op <= SHF_LSH;
      shf_regs <= {4'h6, 4'h7, 4'h3};
      go(1'b0, 1'b1, 1'b1);
      go(1'b0, 1'b0, 1'b0);
      mem_rd(0, 4'h3, fx(32'hC));
      mem_rd(0, 4'h4, fx(32'h23));
      mem_rd(1, 4'h5, fx(32'h54));
      mem_rd(1, 4'h6, fx(32'hC0));
   endtask
   // secondary idles in single-data mode, follows in multiple-data mode
   task t_simd();
      mem_wr(2, 4'h1, fx(32'hA));
      mem_wr(2, 4'h2, fx(32'h1E));
      alu_op <= ALU_ADD;
      alu_regs <= {4'h8, 4'h2, 4'h1};
      go(1'b1, 1'b0, 1'b0);
      simd_en <= 1'b1;
      alu_op <= ALU_SUB;
      alu_regs <= {4'h9, 4'h1, 4'h2};
      go(1'b1, 1'b0, 1'b0);
      simd_en <= 1'b0;
      go(1'b0, 1'b0, 1'b0);
      mem_rd(0, 4'h8, fx(32'hC));
      mem_rd(2, 4'h8, fx(32'h0));
      mem_rd(0, 4'h9, fx(32'h2));
      mem_rd(3, 4'h9, fx(32'h14));
   endtask
   // float32 drops the low byte, float40 keeps it
   task t_float();
      mem_wr(0, 4'hB, 40'h3F_8000_0080);
      fmt <= FMT_F32;
      alu_op <= ALU_ADD;
      alu_regs <= {4'hC, 4'hB, 4'hB};
      go(1'b1, 1'b0, 1'b0);
      fmt <= FMT_F40;
      alu_regs <= {4'hD, 4'hB, 4'hB};
      go(1'b1, 1'b0, 1'b0);
      fmt <= FMT_FIX;
      go(1'b0, 1'b0, 1'b0);
      mem_rd(0, 4'hC, 40'h40_0000_0000);
      mem_rd(0, 4'hD, 40'h40_0000_0080);
   endtask
   // overflow latched and cleared, then pulsed, then read as unsigned
   task t_exc();
      mem_wr(0, 4'h1, fx(32'h7FFF_FFFF));
      mem_wr(0, 4'h2, fx(32'h1));
      alu_regs <= {4'h3, 4'h2, 4'h1};
      go(1'b1, 1'b0, 1'b0);
      go(1'b0, 1'b0, 1'b0);
      chk_st({exc_irq, flags}, 9'h001);
      flag_clr <= 8'h01;
      go(1'b0, 1'b0, 1'b0);
      flag_clr <= 8'h00;
      go(1'b0, 1'b0, 1'b0);
      chk_st({exc_irq, flags}, 9'h000);
      exc_irq_mode <= 1'b1;
      go(1'b1, 1'b0, 1'b0);
      go(1'b0, 1'b0, 1'b0);
      chk_st({exc_irq, flags}, 9'h100);
      exc_irq_mode <= 1'b0;
      fix_uns <= 1'b1;
      go(1'b1, 1'b0, 1'b0);
      go(1'b0, 1'b0, 1'b0);
      chk_st({exc_irq, flags}, 9'h000);
   endtask
   // accumulate, clear, subtract; field extract and exponent
   task t_mac();
      mem_wr(0, 4'h1, fx(32'h6));
      mem_wr(0, 4'h2, fx(32'h3));
      mem_wr(0, 4'h3, fx(32'h104));
      fix_uns <= 1'b0;
      mul_regs <= {4'hA, 4'h2, 4'h1};
      mul_op <= MUL_MUL;
      go(1'b0, 1'b1, 1'b0);
      mul_op <= MUL_MAC;
      go(1'b0, 1'b1, 1'b0);
      mul_op <= MUL_CLR;
      go(1'b0, 1'b1, 1'b0);
      mul_op <= MUL_MSUB;
      mul_regs <= {4'hE, 4'h2, 4'h1};
      shf_op <= SHF_FEXT;
      shf_regs <= {4'hC, 4'h3, 4'hA};
      go(1'b0, 1'b1, 1'b1);
      shf_op <= SHF_EXP;
      shf_regs <= {4'hD, 4'h3, 4'h1};
      go(1'b0, 1'b0, 1'b1);
      go(1'b0, 1'b0, 1'b0);
      mem_rd(0, 4'hA, fx(32'h24));
      mem_rd(0, 4'hE, fx(32'hFFFF_FFEE));
      mem_rd(0, 4'hC, fx(32'h2));
      mem_rd(0, 4'hD, fx(32'hFFFF_FFE4));
   endtask
   // main sequence
   initial begin
      {nrst, simd_en, alt_bank, exc_irq_mode, fix_uns, fix_frac} = 6'h00;
      {alu_en, mul_en, shf_en, alu_regs, mul_regs, shf_regs} = '0;
      {c_en, c_we, c_addr, c_wdata, flag_clr} = '0;
      fmt = FMT_FIX;
      alu_op = ALU_ADD;
      mul_op = MUL_MUL;
      shf_op = SHF_LSH;
      n_mismatch = 0;
      n_checks = 0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      t_bank();
      t_fwd();
      t_simd();
      t_float();
      t_exc();
      t_mac();
      close_out();
   end
   // bound on the whole run, counted as a mismatch
   initial begin
      repeat (3000) @(posedge clk_sys);
      n_mismatch++;
      close_out();
   end
endmodule
